/* rtl/vat_pkg.sv */
// Purpose: constants and types of the address translation block
// Assumes: 32-bit apb data, one word per register
// Notes: page table entry layout is fixed here
package vat_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_FIRST_BASE = 8'h00;
  localparam logic [7:0] OFS_FIRST_LEN = 8'h04;
  localparam logic [7:0] OFS_SECOND_BASE = 8'h08;
  localparam logic [7:0] OFS_SECOND_LEN = 8'h0c;
  localparam logic [7:0] OFS_SYS_BASE = 8'h10;
  localparam logic [7:0] OFS_SYS_LEN = 8'h14;
  localparam logic [7:0] OFS_MODE = 8'h18;
  localparam logic [7:0] OFS_PCB = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_MASK = 8'h24;
  localparam logic [7:0] OFS_FAULT_VA = 8'h28;
  // reset values
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam logic [21:0] RST_LEN = 22'h00_0000;
  localparam logic [1:0] RST_MODE = 2'h0;
  // status and mask bits
  localparam int ST_FAULT = 0;
  localparam int ST_CTX = 1;
  localparam int ST_W = 2;
  // address fields
  localparam int OFS_W = 9;
  localparam int VPN_W = 21;
  localparam int LEN_W = 22;
  localparam int PA_W = 30;
  localparam int TAG_W = 23;
  // page table entry fields
  localparam int PTE_VALID = 31;
  localparam int PTE_PROT_HI = 28;
  localparam int PTE_PROT_LO = 27;
  localparam int PTE_WRITE = 26;
  // context block holds four longwords
  localparam logic [1:0] CTX_LAST = 2'h3;
  localparam int TLB_N = 4;
  // access modes, kernel widest
  typedef enum logic [1:0] {
    MODE_KERNEL = 2'b00,
    MODE_EXEC = 2'b01,
    MODE_SUPER = 2'b10,
    MODE_USER = 2'b11
  } vat_mode_e;
  typedef enum logic [1:0] {
    REG_FIRST = 2'b00,
    REG_SECOND = 2'b01,
    REG_SYS = 2'b10
  } vat_region_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOK = 3'b001,
    ST_SFETCH = 3'b010,
    ST_PFETCH = 3'b011,
    ST_CTXLD = 3'b100
  } vat_state_e;
endpackage

/* rtl/vat_tlb.sv */
// Purpose: small fully associative translation cache
// Assumes: fill only on a miss, never in a flush cycle
// Notes: round robin replacement
`timescale 1ns/1ns
module vat_tlb (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // lookup
  input wire logic [vat_pkg::TAG_W-1:0] look_tag,
  output logic hit,
  output logic [31:0] hit_pte,
  // fill and flush
  input wire logic fill_en,
  input wire logic [vat_pkg::TAG_W-1:0] fill_tag,
  input wire logic [31:0] fill_pte,
  input wire logic flush_proc
);
  typedef struct packed {
    logic [vat_pkg::TLB_N-1:0] vld;
    logic [vat_pkg::TLB_N-1:0][vat_pkg::TAG_W-1:0] tag;
    logic [vat_pkg::TLB_N-1:0][31:0] pte;
    logic [1:0] ptr;
  } vat_tlb_s;

  vat_tlb_s s_r;
  vat_tlb_s s_nxt;

  always_comb begin
    hit = 1'b0;
    hit_pte = 32'h0000_0000;
    for (int i = 0; i < vat_pkg::TLB_N; i++) begin
      if (s_r.vld[i] && s_r.tag[i] == look_tag) begin
        hit = 1'b1;
        hit_pte = s_r.pte[i];
      end
    end
  end

  always_comb begin
    s_nxt = s_r;
    // process entries go, system entries stay
    if (flush_proc) begin
      for (int i = 0; i < vat_pkg::TLB_N; i++) begin
        if (!s_r.tag[i][vat_pkg::TAG_W-1]) begin
          s_nxt.vld[i] = 1'b0;
        end
      end
    end
    if (fill_en) begin
      s_nxt.vld[s_r.ptr] = 1'b1;
      s_nxt.tag[s_r.ptr] = fill_tag;
      s_nxt.pte[s_r.ptr] = fill_pte;
      s_nxt.ptr = s_r.ptr + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

/* rtl/vat_mmu.sv */
// Purpose: virtual to physical translation with protection check
// Assumes: requester and memory port share pclk
// Notes: one apb wait state on every access
`timescale 1ns/1ns
// Behaviour
// - virtual addresses are 32-bit byte addresses
// - top address bit splits process space from system space
// - pages are 512 bytes on 512-byte boundaries
// - base and length register pairs for both process regions and system
// - each table entry is one longword with frame and protection
// - page number indexes the region table from its base
// - system table base is a physical address
// - process table bases are system virtual addresses, translated first
// - missing process table pages fault instead of hanging
// - four access modes; each access checked against current mode
// - kernel has widest access, user narrowest
// - translation cache avoids walking tables on repeat lookups
// - process mappings are private, shared frames allowed
// - system mapping survives context switches
// - context load fetches process mapping registers from memory
module vat_mmu (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // translation request
  input wire logic tr_req,
  input wire logic tr_write,
  input wire logic [31:0] tr_va,
  output logic tr_done,
  output logic tr_fault,
  output logic [vat_pkg::PA_W-1:0] tr_pa,
  // page table memory read port
  output logic mem_req,
  output logic [vat_pkg::PA_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // interrupt
  output logic irq
);
  typedef struct packed {
    logic [31:0] first_base;
    logic [vat_pkg::LEN_W-1:0] first_len;
    logic [31:0] second_base;
    logic [vat_pkg::LEN_W-1:0] second_len;
    logic [31:0] sys_base;
    logic [vat_pkg::LEN_W-1:0] sys_len;
    vat_pkg::vat_mode_e mode;
    logic [31:0] pcb;
    logic ctx_pend;
    logic [1:0] ctx_idx;
    logic [vat_pkg::ST_W-1:0] status;
    logic [vat_pkg::ST_W-1:0] mask;
    logic [31:0] fault_va;
    vat_pkg::vat_state_e state;
    logic [31:0] va;
    logic wr;
    logic [31:0] pte_va;
    logic mem_req;
    logic [vat_pkg::PA_W-1:0] mem_addr;
    logic tr_done;
    logic tr_fault;
    logic [vat_pkg::PA_W-1:0] tr_pa;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } vat_mmu_s;

  vat_mmu_s s_r;
  vat_mmu_s s_nxt;

  logic tlb_hit;
  logic [31:0] tlb_pte;
  logic tlb_fill;
  logic tlb_flush;

  // region from the two top address bits
  function automatic vat_pkg::vat_region_e region_of(
    input logic [31:0] va
  );
    if (va[31]) begin
      return vat_pkg::REG_SYS;
    end else if (va[30]) begin
      return vat_pkg::REG_SECOND;
    end else begin
      return vat_pkg::REG_FIRST;
    end
  endfunction

  function automatic logic [vat_pkg::VPN_W-1:0] vpn_of(
    input logic [31:0] va
  );
    return va[29:vat_pkg::OFS_W];
  endfunction

  // mode code must not exceed the entry's protection code
  function automatic logic access_ok(
    input logic [31:0] pte,
    input vat_pkg::vat_mode_e mode,
    input logic wr
  );
    logic prot_ok;
    prot_ok = mode <= pte[vat_pkg::PTE_PROT_HI:vat_pkg::PTE_PROT_LO];
    return pte[vat_pkg::PTE_VALID] && prot_ok &&
           (!wr || pte[vat_pkg::PTE_WRITE]);
  endfunction

  // physical address of a table entry
  function automatic logic [vat_pkg::PA_W-1:0] ent_addr(
    input logic [31:0] base,
    input logic [vat_pkg::VPN_W-1:0] vpn
  );
    return base[vat_pkg::PA_W-1:0] + {7'h00, vpn, 2'b00};
  endfunction

  function automatic logic reg_known(input logic [31:0] a);
    logic ok;
    ok = a[31:8] == 24'h00_0000 && a[1:0] == 2'b00 &&
         a[7:0] <= vat_pkg::OFS_FAULT_VA;
    return ok;
  endfunction

  vat_tlb u_tlb (
    .pclk(pclk),
    .presetn(presetn),
    .look_tag(s_r.va[31:vat_pkg::OFS_W]),
    .hit(tlb_hit),
    .hit_pte(tlb_pte),
    .fill_en(tlb_fill),
    .fill_tag(s_r.va[31:vat_pkg::OFS_W]),
    .fill_pte(mem_rdata),
    .flush_proc(tlb_flush)
  );

  always_comb begin
    logic acc;
    logic [vat_pkg::ST_W-1:0] sts_set;
    logic [vat_pkg::ST_W-1:0] sts_clr;
    logic fin;
    logic fin_fault;
    logic [31:0] fin_pte;
    logic [31:0] rbase;
    logic [vat_pkg::LEN_W-1:0] rlen;
    logic [vat_pkg::VPN_W-1:0] vpn;
    logic [31:0] pva;
    logic [vat_pkg::VPN_W-1:0] svpn;
    acc = 1'b0;
    sts_set = '0;
    sts_clr = '0;
    fin = 1'b0;
    fin_fault = 1'b0;
    fin_pte = 32'h0000_0000;
    rbase = s_r.first_base;
    rlen = s_r.first_len;
    vpn = vpn_of(s_r.va);
    pva = 32'h0000_0000;
    svpn = '0;
    tlb_fill = 1'b0;
    tlb_flush = 1'b0;
    s_nxt = s_r;
    s_nxt.tr_done = 1'b0;

    // apb: setup seen, answer one cycle into access
    s_nxt.pready = psel && penable && !s_r.pready;
    // error only stands beside ready
    s_nxt.pslverr = 1'b0;
    if (psel && penable && !s_r.pready) begin
      s_nxt.pslverr = !reg_known(paddr);
      s_nxt.prdata = 32'h0000_0000;
      unique case (paddr[7:0])
        vat_pkg::OFS_FIRST_BASE: s_nxt.prdata = s_r.first_base;
        vat_pkg::OFS_FIRST_LEN: s_nxt.prdata = {10'h000, s_r.first_len};
        vat_pkg::OFS_SECOND_BASE: s_nxt.prdata = s_r.second_base;
        vat_pkg::OFS_SECOND_LEN: s_nxt.prdata = {10'h000, s_r.second_len};
        vat_pkg::OFS_SYS_BASE: s_nxt.prdata = s_r.sys_base;
        vat_pkg::OFS_SYS_LEN: s_nxt.prdata = {10'h000, s_r.sys_len};
        vat_pkg::OFS_MODE: s_nxt.prdata = {30'h0, s_r.mode};
        vat_pkg::OFS_PCB: s_nxt.prdata = s_r.pcb;
        vat_pkg::OFS_STATUS: s_nxt.prdata = {30'h0, s_r.status};
        vat_pkg::OFS_MASK: s_nxt.prdata = {30'h0, s_r.mask};
        vat_pkg::OFS_FAULT_VA: s_nxt.prdata = s_r.fault_va;
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
      if (s_nxt.pslverr) begin
        s_nxt.prdata = 32'h0000_0000;
      end
    end
    acc = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
    if (acc) begin
      unique case (paddr[7:0])
        vat_pkg::OFS_FIRST_BASE: s_nxt.first_base = pwdata;
        vat_pkg::OFS_FIRST_LEN: s_nxt.first_len = pwdata[21:0];
        vat_pkg::OFS_SECOND_BASE: s_nxt.second_base = pwdata;
        vat_pkg::OFS_SECOND_LEN: s_nxt.second_len = pwdata[21:0];
        vat_pkg::OFS_SYS_BASE: s_nxt.sys_base = pwdata;
        vat_pkg::OFS_SYS_LEN: s_nxt.sys_len = pwdata[21:0];
        vat_pkg::OFS_MODE: begin
          s_nxt.mode = vat_pkg::vat_mode_e'(pwdata[1:0]);
        end
        vat_pkg::OFS_PCB: begin
          s_nxt.pcb = pwdata;
          s_nxt.ctx_pend = 1'b1;
        end
        vat_pkg::OFS_STATUS: sts_clr = pwdata[1:0];
        vat_pkg::OFS_MASK: s_nxt.mask = pwdata[1:0];
        default: s_nxt.mask = s_r.mask;
      endcase
    end

    // region registers for the held address
    unique case (region_of(s_r.va))
      vat_pkg::REG_SECOND: begin
        rbase = s_r.second_base;
        rlen = s_r.second_len;
      end
      vat_pkg::REG_SYS: begin
        rbase = s_r.sys_base;
        rlen = s_r.sys_len;
      end
      default: begin
        rbase = s_r.first_base;
        rlen = s_r.first_len;
      end
    endcase
    pva = rbase + {9'h000, vpn, 2'b00};
    svpn = vpn_of(s_r.pte_va);

    unique case (s_r.state)
      vat_pkg::ST_IDLE: begin
        if (s_r.ctx_pend && !acc) begin
          s_nxt.ctx_pend = 1'b0;
          s_nxt.ctx_idx = 2'h0;
          s_nxt.mem_req = 1'b1;
          s_nxt.mem_addr = s_r.pcb[vat_pkg::PA_W-1:0];
          s_nxt.state = vat_pkg::ST_CTXLD;
        end else if (tr_req && !s_r.tr_done) begin
          s_nxt.va = tr_va;
          s_nxt.wr = tr_write;
          s_nxt.state = vat_pkg::ST_LOOK;
        end
      end
      vat_pkg::ST_LOOK: begin
        if ({1'b0, vpn} >= rlen) begin
          fin = 1'b1;
          fin_fault = 1'b1;
        end else if (tlb_hit) begin
          fin = 1'b1;
          fin_pte = tlb_pte;
          fin_fault = !access_ok(tlb_pte, s_r.mode, s_r.wr);
        end else if (region_of(s_r.va) == vat_pkg::REG_SYS) begin
          s_nxt.mem_req = 1'b1;
          s_nxt.mem_addr = ent_addr(s_r.sys_base, vpn);
          s_nxt.state = vat_pkg::ST_PFETCH;
        end else if (!pva[31] ||
                     {1'b0, vpn_of(pva)} >= s_r.sys_len) begin
          fin = 1'b1;
          fin_fault = 1'b1;
        end else begin
          s_nxt.pte_va = pva;
          s_nxt.mem_req = 1'b1;
          s_nxt.mem_addr = ent_addr(s_r.sys_base, vpn_of(pva));
          s_nxt.state = vat_pkg::ST_SFETCH;
        end
      end
      vat_pkg::ST_SFETCH: begin
        if (mem_ack) begin
          if (!mem_rdata[vat_pkg::PTE_VALID]) begin
            s_nxt.mem_req = 1'b0;
            fin = 1'b1;
            fin_fault = 1'b1;
          end else begin
            s_nxt.mem_addr = {mem_rdata[vat_pkg::VPN_W-1:0],
                              s_r.pte_va[vat_pkg::OFS_W-1:0]};
            s_nxt.state = vat_pkg::ST_PFETCH;
          end
        end
      end
      vat_pkg::ST_PFETCH: begin
        if (mem_ack) begin
          s_nxt.mem_req = 1'b0;
          tlb_fill = mem_rdata[vat_pkg::PTE_VALID];
          fin = 1'b1;
          fin_pte = mem_rdata;
          fin_fault = !access_ok(mem_rdata, s_r.mode, s_r.wr);
        end
      end
      vat_pkg::ST_CTXLD: begin
        if (mem_ack) begin
          unique case (s_r.ctx_idx)
            2'h0: s_nxt.first_base = mem_rdata;
            2'h1: s_nxt.first_len = mem_rdata[21:0];
            2'h2: s_nxt.second_base = mem_rdata;
            2'h3: s_nxt.second_len = mem_rdata[21:0];
          endcase
          s_nxt.ctx_idx = s_r.ctx_idx + 2'h1;
          s_nxt.mem_addr = s_r.mem_addr + 30'h4;
          if (s_r.ctx_idx == vat_pkg::CTX_LAST) begin
            s_nxt.mem_req = 1'b0;
            tlb_flush = 1'b1;
            sts_set[vat_pkg::ST_CTX] = 1'b1;
            s_nxt.state = vat_pkg::ST_IDLE;
          end
        end
      end
      default: s_nxt.state = vat_pkg::ST_IDLE;
    endcase

    if (fin) begin
      s_nxt.state = vat_pkg::ST_IDLE;
      s_nxt.tr_done = 1'b1;
      s_nxt.tr_fault = fin_fault;
      s_nxt.tr_pa = fin_fault ? '0 :
        {fin_pte[vat_pkg::VPN_W-1:0],
         s_r.va[vat_pkg::OFS_W-1:0]};
      if (fin_fault) begin
        sts_set[vat_pkg::ST_FAULT] = 1'b1;
        s_nxt.fault_va = s_r.va;
      end
    end

    // set beats a same-cycle clear
    s_nxt.status = (s_r.status & ~sts_clr) | sts_set;
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.first_base <= vat_pkg::RST_BASE;
      s_r.first_len <= vat_pkg::RST_LEN;
      s_r.second_base <= vat_pkg::RST_BASE;
      s_r.second_len <= vat_pkg::RST_LEN;
      s_r.sys_base <= vat_pkg::RST_BASE;
      s_r.sys_len <= vat_pkg::RST_LEN;
      s_r.mode <= vat_pkg::vat_mode_e'(vat_pkg::RST_MODE);
      s_r.state <= vat_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign tr_done = s_r.tr_done;
  assign tr_fault = s_r.tr_fault;
  assign tr_pa = s_r.tr_pa;
  assign mem_req = s_r.mem_req;
  assign mem_addr = s_r.mem_addr;
  assign irq = s_r.irq;
endmodule

/* verification/vat_mem_model.sv */
// Purpose: page table memory model facing the translation block
// Assumes: one longword read at a time, request held until ack
// Notes: latency 1 or 5 cycles, chosen by address bit 3
`timescale 1ns/1ns
module vat_mem_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // read port
  input wire logic mem_req,
  input wire logic [vat_pkg::PA_W-1:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:1023];
  logic [2:0] cnt;
  initial begin
    foreach (mem[i]) mem[i] = 32'h0000_0000;
    // resident contiguous system table at 0x400
    mem[10'h100] = 32'h8400_0055;
    mem[10'h101] = 32'h9800_0001;
    // process table page at 0x200
    mem[10'h080] = 32'h9c00_00aa;
    mem[10'h081] = 32'h8800_00bb;
    // context block at 0x300
    mem[10'h0c0] = 32'h8000_0200;
    mem[10'h0c1] = 32'h0000_0001;
    mem[10'h0c2] = 32'h8000_0200;
    mem[10'h0c3] = 32'h0000_0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req && !mem_ack
                 && cnt == (mem_addr[3] ? 3'h4 : 3'h0)) begin
      cnt <= 3'h0;
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[11:2]];
    end else begin
      mem_ack <= 1'b0;
      // data not valid outside ack
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) cnt <= cnt + 3'h1;
    end
  end
endmodule

/* verification/vat_mmu_chk.sv */
// Purpose: port assertions of the translation block
// Assumes: one clock domain, async active-low reset
// Notes: attached by bind at the foot
`timescale 1ns/1ns
module vat_mmu_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // translation
  input wire logic tr_req,
  input wire logic [31:0] tr_va,
  input wire logic tr_done,
  input wire logic tr_fault,
  input wire logic [vat_pkg::PA_W-1:0] tr_pa,
  // memory
  input wire logic mem_req,
  input wire logic [vat_pkg::PA_W-1:0] mem_addr,
  input wire logic mem_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not on time");
  a_apb_unmapped: assert property (pready && paddr > 32'h28 |-> pslverr)
    else $error("unmapped access not refused");
  a_err_alone: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_done_pulse: assert property (tr_done |=> !tr_done)
    else $error("done longer than one cycle");
  a_answer_bound: assert property ($rose(tr_req) |-> ##[1:3] (tr_done || mem_req))
    else $error("no lookup answer or fetch");
  a_offset_keep: assert property (tr_done && !tr_fault |-> tr_pa[8:0] == tr_va[8:0])
    else $error("page offset altered");
  a_fault_nopa: assert property (tr_done && tr_fault |-> !(|tr_pa))
    else $error("address given on fault");
  a_result_held: assert property ($changed(tr_pa) || $changed(tr_fault) |-> tr_done)
    else $error("result changed without answer");
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch dropped before ack");
  a_mem_word: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("fetch not longword aligned");
  cover property (tr_done && tr_fault);
  cover property (tr_done && !tr_fault);
  cover property (pready && pslverr);
  cover property ($rose(mem_req));
endmodule
bind vat_mmu vat_mmu_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .tr_req(tr_req), .tr_va(tr_va), .tr_done(tr_done), .tr_fault(tr_fault),
  .tr_pa(tr_pa), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack));

/* verification/tb_top.sv */
// Purpose: self-checking bench of the translation block
// Assumes: memory model holds the tables and context block
// Notes: rows cover walks, hits and faults; rest hand-written
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [31:0] va;
    logic wr;
    logic [1:0] mode;
    logic flt;
    logic [29:0] pa;
  } vat_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, mem_rdata, rd;
  logic pready, pslverr, tr_done, tr_fault, mem_req, mem_ack, irq, err, flt;
  logic tr_req = 1'b0, tr_write = 1'b0;
  logic [31:0] tr_va = 32'h0;
  logic [29:0] tr_pa, mem_addr, pa;
  int n_fail = 0, num_checks = 0;
  vat_row_s rows [11] = '{
    {32'h8000_0123, 1'h1, 2'h0, 1'h0, 30'h0000ab23},
    {32'h8000_01ff, 1'h0, 2'h0, 1'h0, 30'h0000abff},
    {32'h8000_0123, 1'h0, 2'h3, 1'h1, 30'h0},
    {32'h8000_0400, 1'h0, 2'h0, 1'h1, 30'h0},
    {32'h8000_0800, 1'h0, 2'h0, 1'h1, 30'h0},
    {32'h0000_01ff, 1'h1, 2'h3, 1'h0, 30'h000155ff},
    {32'h0000_0210, 1'h0, 2'h3, 1'h1, 30'h0},
    {32'h0000_0210, 1'h0, 2'h1, 1'h0, 30'h00017610},
    {32'h0000_0210, 1'h1, 2'h1, 1'h1, 30'h0},
    {32'h4000_0000, 1'h0, 2'h0, 1'h1, 30'h0},
    {32'h0000_0400, 1'h0, 2'h0, 1'h1, 30'h0}};
  always #20 pclk = ~pclk;
  vat_mmu uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tr_req(tr_req),
    .tr_write(tr_write), .tr_va(tr_va), .tr_done(tr_done),
    .tr_fault(tr_fault), .tr_pa(tr_pa), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .irq(irq));
  vat_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // pready ends this wait; the watchdog catches a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic xl(input logic [31:0] va, input logic w);
    @(posedge pclk);
    tr_req <= 1'b1;
    tr_va <= va;
    tr_write <= w;
    @(posedge pclk);
    while (tr_done !== 1'b1) begin
      @(posedge pclk);
    end
    flt = tr_fault;
    pa = tr_pa;
    tr_req <= 1'b0;
  endtask
  initial begin
    #(40 * 20000);
    n_fail++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h2c, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, vat_pkg::OFS_SECOND_LEN, 32'hffff_ffff);
    apb(1'b0, vat_pkg::OFS_SECOND_LEN, 32'h0);
    chk(rd, 32'h003f_ffff);
    apb(1'b1, vat_pkg::OFS_SECOND_LEN, 32'h0);
    // table bases and lengths before use
    apb(1'b1, vat_pkg::OFS_SYS_BASE, 32'h400);
    apb(1'b1, vat_pkg::OFS_SYS_LEN, 32'h4);
    apb(1'b1, vat_pkg::OFS_FIRST_BASE, 32'h8000_0200);
    apb(1'b1, vat_pkg::OFS_FIRST_LEN, 32'h2);
    foreach (rows[i]) begin
      apb(1'b1, vat_pkg::OFS_MODE, {30'h0, rows[i].mode});
      xl(rows[i].va, rows[i].wr);
      chk({31'h0, flt}, {31'h0, rows[i].flt});
      chk({2'h0, pa}, {2'h0, rows[i].pa});
    end
    apb(1'b0, vat_pkg::OFS_FAULT_VA, 32'h0);
    chk(rd, 32'h0000_0400);
    apb(1'b0, vat_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, vat_pkg::OFS_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, vat_pkg::OFS_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, vat_pkg::OFS_MODE, 32'h0);
    apb(1'b1, vat_pkg::OFS_PCB, 32'h300);
    for (int i = 0; i < 50 && rd[1] !== 1'b1; i++)
      apb(1'b0, vat_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, vat_pkg::OFS_SYS_BASE, 32'h0);
    chk(rd, 32'h400);
    xl(32'h8000_0123, 1'b0);
    chk({2'h0, pa}, 32'h0000_ab23);
    xl(32'h4000_0005, 1'b0);
    chk({2'h0, pa}, 32'h0001_5405);
    xl(32'h0000_0210, 1'b0);
    chk({31'h0, flt}, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, vat_pkg::OFS_SYS_BASE, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    test_done();
  end
endmodule
